/* pkg/egress_tag_map.vh */
`ifndef EGRESS_TAG_MAP_VH
`define EGRESS_TAG_MAP_VH
// register offsets (byte addresses)
`define REG_EGRESS_PORT_TAG_CONFIG 8'h00
`define REG_PORT0_DEFAULT_VID_PRIO 8'h04
`define REG_PORT1_DEFAULT_VID_PRIO 8'h08
`define REG_PORT2_DEFAULT_VID_PRIO 8'h0c
`define REG_PORT0_TOTAL_DROP_COUNT 8'h10
`define REG_PORT1_TOTAL_DROP_COUNT 8'h14
`define REG_PORT2_TOTAL_DROP_COUNT 8'h18
`define REG_PORT0_RATE_DROP_COUNT  8'h1c
`define REG_PORT1_RATE_DROP_COUNT  8'h20
`define REG_PORT2_RATE_DROP_COUNT  8'h24
`define REG_EDITOR_STATUS          8'h28
// per-port config field, 8 bits a port at port*8
`define CFG_PORT_TYPE_LSB   0
`define CFG_INSERT_TAG      2
`define CFG_SRC_SELECT      3
`define CFG_CHANGE_TAG      4
`define CFG_CHANGE_VID      5
`define CFG_CHANGE_PRIO     6
`define CFG_RESET           32'h0000_0000
// egress port types
`define PT_PASSIVE 2'h0
`define PT_ACCESS  2'h1
`define PT_HYBRID  2'h2
`define PT_CPU     2'h3
// received tag kinds
`define TK_NONE     2'h0
`define TK_PRIO     2'h1
`define TK_NORMAL   2'h2
`define TK_SPECIAL  2'h3
// edit actions
`define ACT_PASS    2'h0
`define ACT_STRIP   2'h1
`define ACT_INSERT  2'h2
`define ACT_REWRITE 2'h3
`define DEFAULT_VID_PRIO_RESET 16'h0001
`define FIFO_DEPTH  8
`define FIFO_AW     3
`endif

/* verilog/egress_vlan_tag_editor.v */
`timescale 1ns/1ps
`include "egress_tag_map.vh"

module tag_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  // full level held at the counter's width
  localparam [AW:0] FULL = DEPTH;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // tag_fifo

module egress_vlan_tag_editor (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // packet descriptor from transmit queues
  input  wire        pkt_valid,
  output wire        pkt_ready,
  input  wire [1:0]  egress_port,
  input  wire [1:0]  ingress_port,
  input  wire [1:0]  rx_tag_kind,
  input  wire [11:0] rx_vid,
  input  wire [2:0]  rx_prio,
  input  wire [2:0]  ingress_prio,
  // vlan table strip bits: one set for frame vid, one for ingress default vid
  input  wire [2:0]  strip_bits_frame_vid,
  input  wire [2:0]  strip_bits_default_vid,
  // drop events from the buffer manager
  input  wire [2:0]  buffer_drop,
  input  wire [2:0]  rate_drop,
  // edit decision to egress mac
  output wire        edit_valid,
  input  wire        edit_ready,
  output wire [1:0]  edit_action,
  output wire [11:0] edit_vid,
  output wire [2:0]  edit_prio,
  output wire        edit_strip_special,
  output wire        edit_fcs_regen
);
  // decision word: {strip special, action, vid, prio}
  localparam DW          = 18;
  localparam SPECIAL_BIT = 17;
  localparam ACT_LSB     = 15;
  localparam VID_LSB     = 3;

  reg  [31:0] egress_port_tag_config;
  reg  [15:0] default_vid_prio [0:2];
  reg  [31:0] total_drop_count [0:2];
  reg  [31:0] rate_drop_count  [0:2];
  reg  [15:0] edits_done;

  reg  [1:0]  next_action;
  reg  [11:0] next_vid;
  reg  [2:0]  next_prio;
  reg         next_strip_special;
  reg  [31:0] next_rdata;

  wire [7:0]  port_cfg;
  wire [1:0]  port_type;
  wire        strip_def;
  wire        strip_own;
  wire [11:0] sel_vid;
  wire [2:0]  sel_prio;
  wire [15:0] in_def;
  wire [15:0] eg_def;
  wire        fifo_in_ready;
  wire [DW-1:0] fifo_out;
  wire        eg_port_ok;
  wire        in_port_ok;
  wire [7:0]  raw_cfg;
  wire [11:0] in_def_vid;
  wire [11:0] eg_def_vid;
  wire [2:0]  eg_def_prio;
  wire        out_special;
  wire [1:0]  out_action;
  wire        edit_taken;

  function [7:0] cfg_of;
    input [31:0] cfg;
    input [1:0]  port;
    begin
      cfg_of = cfg[port*8 +: 8];
    end
  endfunction

  function reg_hit;
    input       strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_hit = strobe && (addr == offset);
    end
  endfunction

  // port code 3 names no port: it acts as passive with zero defaults rather than index past the tables
  assign eg_port_ok  = (egress_port != 2'h3);
  assign in_port_ok  = (ingress_port != 2'h3);
  assign raw_cfg     = cfg_of(egress_port_tag_config, egress_port);
  assign port_cfg    = eg_port_ok ? raw_cfg : 8'h00;
  assign port_type   = port_cfg[`CFG_PORT_TYPE_LSB +: 2];
  assign in_def      = in_port_ok ? default_vid_prio[ingress_port] : 16'h0000;
  assign eg_def      = eg_port_ok ? default_vid_prio[egress_port] : 16'h0000;
  assign in_def_vid  = in_def[11:0];
  assign eg_def_vid  = eg_def[11:0];
  assign eg_def_prio = eg_def[15:13];
  assign strip_def   = eg_port_ok & strip_bits_default_vid[egress_port];
  assign strip_own   = eg_port_ok & strip_bits_frame_vid[egress_port];
  // source select high takes the egress port defaults
  assign sel_vid     = port_cfg[`CFG_SRC_SELECT] ? eg_def_vid : in_def_vid;
  assign sel_prio    = port_cfg[`CFG_SRC_SELECT] ? eg_def_prio : ingress_prio;

  always @* begin
    next_action        = `ACT_PASS;
    next_vid           = rx_vid;
    next_prio          = rx_prio;
    next_strip_special = 1'b0;
    if (rx_tag_kind == `TK_SPECIAL) begin
      next_strip_special = (port_type != `PT_CPU);
    end else begin
      case (port_type)
        `PT_PASSIVE: next_action = `ACT_PASS;
        `PT_ACCESS: begin
          if (rx_tag_kind != `TK_NONE) begin
            next_action = `ACT_STRIP;
          end
        end
        `PT_HYBRID: begin
          case (rx_tag_kind)
            `TK_NONE: begin
              if (port_cfg[`CFG_INSERT_TAG] && !strip_def) begin
                next_action = `ACT_INSERT;
                next_vid    = sel_vid;
                next_prio   = sel_prio;
              end
            end
            `TK_PRIO: begin
              if (strip_def) begin
                next_action = `ACT_STRIP;
              end else begin
                next_action = `ACT_REWRITE;
                next_vid    = sel_vid;
                if (port_cfg[`CFG_CHANGE_PRIO]) begin
                  next_prio = sel_prio;
                end
              end
            end
            `TK_NORMAL: begin
              if (strip_own) begin
                next_action = `ACT_STRIP;
              end else if (!port_cfg[`CFG_CHANGE_TAG]) begin
                next_action = `ACT_PASS;
              end else if (!port_cfg[`CFG_CHANGE_VID] && !port_cfg[`CFG_CHANGE_PRIO]) begin
                next_action = `ACT_PASS;
              end else begin
                next_action = `ACT_REWRITE;
                if (port_cfg[`CFG_CHANGE_VID]) begin
                  next_vid = sel_vid;
                end
                if (port_cfg[`CFG_CHANGE_PRIO]) begin
                  next_prio = sel_prio;
                end
              end
            end
            default: next_action = `ACT_PASS;
          endcase
        end
        default: next_action = `ACT_PASS;
      endcase
    end
  end

  // decisions are queued so a stalled mac back-pressures the queues
  assign pkt_ready = fifo_in_ready;

  tag_fifo #(
    .WIDTH (DW),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (pkt_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({next_strip_special, next_action, next_vid, next_prio}),
    .out_valid (edit_valid),
    .out_ready (edit_ready),
    .out_data  (fifo_out)
  );

  assign out_special        = fifo_out[SPECIAL_BIT];
  assign out_action         = fifo_out[ACT_LSB +: 2];
  assign edit_strip_special = out_special;
  assign edit_action        = out_action;
  assign edit_vid           = fifo_out[VID_LSB +: 12];
  assign edit_prio          = fifo_out[2:0];
  assign edit_fcs_regen     = (out_action != `ACT_PASS) | out_special;
  assign edit_taken         = edit_valid & edit_ready;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cnt
      localparam [7:0] DEF_ADDR = `REG_PORT0_DEFAULT_VID_PRIO + 4 * g;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          total_drop_count[g] <= 32'h0000_0000;
          rate_drop_count[g]  <= 32'h0000_0000;
        end else begin
          // a rate drop also counts in the total
          if (buffer_drop[g] || rate_drop[g]) begin
            total_drop_count[g] <= total_drop_count[g] + 32'h0000_0001;
          end
          if (rate_drop[g]) begin
            rate_drop_count[g] <= rate_drop_count[g] + 32'h0000_0001;
          end
        end
      end
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          default_vid_prio[g] <= `DEFAULT_VID_PRIO_RESET;
        end else if (reg_hit(reg_wr, reg_addr, DEF_ADDR)) begin
          default_vid_prio[g] <= reg_wdata[15:0];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      egress_port_tag_config <= `CFG_RESET;
      edits_done             <= 16'h0000;
    end else begin
      if (reg_hit(reg_wr, reg_addr, `REG_EGRESS_PORT_TAG_CONFIG)) begin
        egress_port_tag_config <= reg_wdata;
      end
      // counts frames handed to the mac that need a new checksum
      if (edit_taken && edit_fcs_regen) begin
        edits_done <= edits_done + 16'h0001;
      end
    end
  end

  // read data built here, registered below so it stands only in the cycle after the strobe
  always @* begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_EGRESS_PORT_TAG_CONFIG: next_rdata = egress_port_tag_config;
        `REG_PORT0_DEFAULT_VID_PRIO: next_rdata = {16'h0000, default_vid_prio[0]};
        `REG_PORT1_DEFAULT_VID_PRIO: next_rdata = {16'h0000, default_vid_prio[1]};
        `REG_PORT2_DEFAULT_VID_PRIO: next_rdata = {16'h0000, default_vid_prio[2]};
        `REG_PORT0_TOTAL_DROP_COUNT: next_rdata = total_drop_count[0];
        `REG_PORT1_TOTAL_DROP_COUNT: next_rdata = total_drop_count[1];
        `REG_PORT2_TOTAL_DROP_COUNT: next_rdata = total_drop_count[2];
        `REG_PORT0_RATE_DROP_COUNT:  next_rdata = rate_drop_count[0];
        `REG_PORT1_RATE_DROP_COUNT:  next_rdata = rate_drop_count[1];
        `REG_PORT2_RATE_DROP_COUNT:  next_rdata = rate_drop_count[2];
        `REG_EDITOR_STATUS:          next_rdata = {14'h0000, fifo_in_ready, edit_valid, edits_done};
        default:                     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // egress_vlan_tag_editor

/* testbench/egress_mac_model.sv */
`timescale 1ns/1ps
module egress_mac_model (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // pacing from the bench
  input  wire       stall,
  input  wire       slow,
  // decision stream
  input  wire       edit_valid,
  output reg        edit_ready,
  output reg  [7:0] pops
);
  // slow mode takes a decision only every other cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edit_ready <= 1'b0;
      pops       <= 8'h00;
    end else begin
      edit_ready <= !stall && (!slow || !edit_ready);
      if (edit_valid && edit_ready) pops <= pops + 8'h01;
    end
  end
endmodule // egress_mac_model

/* testbench/egress_vlan_tag_editor_chk.sv */
`timescale 1ns/1ps
`include "egress_tag_map.vh"
module egress_vlan_tag_editor_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // watched ports
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        pkt_valid,
  input wire        pkt_ready,
  input wire        edit_valid,
  input wire        edit_ready,
  input wire [1:0]  edit_action,
  input wire [11:0] edit_vid,
  input wire [2:0]  edit_prio,
  input wire        edit_strip_special,
  input wire        edit_fcs_regen
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence taken_s;
    pkt_valid && pkt_ready;
  endsequence
  sequence stalled_s;
    edit_valid && !edit_ready;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  push_answer_a: assert property (taken_s |=> edit_valid)
    else $error("accepted descriptor gave no decision");
  hold_stable_a: assert property (stalled_s |=> edit_valid && $stable({edit_action, edit_vid, edit_prio}))
    else $error("decision changed while stalled");
  fcs_on_a: assert property (edit_valid && (edit_action != `ACT_PASS || edit_strip_special) |-> edit_fcs_regen)
    else $error("edit without checksum regeneration");
  fcs_off_a: assert property (edit_valid && edit_action == `ACT_PASS && !edit_strip_special |-> !edit_fcs_regen)
    else $error("checksum regenerated on untouched frame");
  special_pass_a: assert property (edit_valid && edit_strip_special |-> edit_action == `ACT_PASS)
    else $error("special strip with other action");
  empty_ready_a: assert property (!edit_valid |-> pkt_ready)
    else $error("empty queue refused descriptor");
  empty_stays_a: assert property (!edit_valid && !(pkt_valid && pkt_ready) |=> !edit_valid)
    else $error("decision appeared without descriptor");
endmodule // egress_vlan_tag_editor_chk

bind egress_vlan_tag_editor egress_vlan_tag_editor_chk egress_vlan_tag_editor_chk_inst (.clk_sys, .rst, .reg_rd,
  .reg_rdata, .pkt_valid, .pkt_ready, .edit_valid, .edit_ready, .edit_action, .edit_vid, .edit_prio,
  .edit_strip_special, .edit_fcs_regen);

/* testbench/egress_vlan_tag_editor_test.sv */
`timescale 1ns/1ps
`include "egress_tag_map.vh"
module egress_vlan_tag_editor_test;
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pkt_valid = 1'b0;
  logic        stall = 1'b0, slow = 1'b0, edit_valid, edit_ready, pkt_ready, edit_strip_special, edit_fcs_regen;
  logic [7:0]  reg_addr = 8'h00, pops, base;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0]  strip_f = 3'h0, strip_d = 3'h0, buffer_drop = 3'h0, rate_drop = 3'h0, edit_prio;
  logic [1:0]  rx_tag_kind = 2'h0, edit_action, egress_port = 2'h1, ingress_port = 2'h0;
  logic [11:0] edit_vid;
  logic [19:0] r;
  int          num_errors = 0, tests_run = 0, n, acc;
  // row: config byte, tag kind, {strip frame, strip default}, action
  logic [19:0] rows [22] = '{20'h00000, 20'h00100, 20'h00200, 20'h00300, 20'h01000, 20'h01101, 20'h01201,
    20'h01300, 20'h03300, 20'h06002, 20'h06010, 20'h02000, 20'h0e002, 20'h02111, 20'h02123, 20'h4a103,
    20'h02221, 20'h02210, 20'h12200, 20'h32203, 20'h5a203, 20'h02300};
  always #25 clk_sys = ~clk_sys;
  egress_vlan_tag_editor egress_vlan_tag_editor_inst (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pkt_valid, .pkt_ready, .egress_port, .ingress_port, .rx_tag_kind, .rx_vid(12'h123),
    .rx_prio(3'h5), .ingress_prio(3'h3), .strip_bits_frame_vid(strip_f), .strip_bits_default_vid(strip_d),
    .buffer_drop, .rate_drop, .edit_valid, .edit_ready, .edit_action, .edit_vid, .edit_prio,
    .edit_strip_special, .edit_fcs_regen);
  egress_mac_model egress_mac_model_inst (.clk_sys, .rst, .stall, .slow, .edit_valid, .edit_ready, .pops);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic conclude();
    $display("errors %0d tests %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 4000);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wr(`REG_PORT0_DEFAULT_VID_PRIO, 32'h2005);
    wr(`REG_PORT1_DEFAULT_VID_PRIO, 32'hc00a);
    foreach (rows[i]) begin
      r = rows[i];
      // other ports set to processor type to catch wrong byte selection
      wr(`REG_EGRESS_PORT_TAG_CONFIG, {8'h00, 8'h03, r[19:12], 8'h03});
      @(posedge clk_sys);
      pkt_valid <= 1'b1;
      rx_tag_kind <= r[9:8];
      strip_f <= {~r[5], r[5], ~r[5]};
      strip_d <= {~r[4], r[4], ~r[4]};
      @(posedge clk_sys);
      pkt_valid <= 1'b0;
      n = 0;
      do @(negedge clk_sys); while (!(edit_valid && edit_ready) && ++n < 20);
      chk(edit_action, r[1:0]);
      chk(edit_strip_special, r[9:8] == 2'h3 && r[13:12] != 2'h3);
      chk(edit_fcs_regen, r[1:0] != 2'h0 || (r[9:8] == 2'h3 && r[13:12] != 2'h3));
      if (r[1]) begin
        chk(edit_vid, (r[9:8] == 2'h2 && !r[17]) ? 12'h123 : (r[15] ? 12'h00a : 12'h005));
        chk(edit_prio, (r[9:8] != 2'h0 && !r[18]) ? 3'h5 : (r[15] ? 3'h6 : 3'h3));
      end
    end
    // port 2 egress, port 1 ingress: byte and strip bit of port 2, default of port 1
    wr(`REG_EGRESS_PORT_TAG_CONFIG, 32'h0006_0303);
    @(posedge clk_sys);
    egress_port <= 2'h2;
    ingress_port <= 2'h1;
    pkt_valid <= 1'b1;
    rx_tag_kind <= 2'h0;
    strip_f <= 3'b100;
    strip_d <= 3'b011;
    @(posedge clk_sys);
    pkt_valid <= 1'b0;
    @(negedge clk_sys);
    chk({edit_valid, edit_action, edit_vid, edit_prio}, {1'b1, 2'h2, 12'h00a, 3'h3});
    for (int p = 0; p < 3; p++) begin
      wr(8'h04 + 8'(4 * p), 32'h1000 + p);
      rd(8'h04 + 8'(4 * p), 32'h1000 + p);
    end
    rd(8'h40, 32'h0);
    wr(`REG_PORT0_TOTAL_DROP_COUNT, 32'h5);
    @(posedge clk_sys);
    buffer_drop <= 3'b101;
    rate_drop <= 3'b110;
    @(posedge clk_sys);
    buffer_drop <= 3'b001;
    rate_drop <= 3'b010;
    @(posedge clk_sys);
    buffer_drop <= 3'b000;
    @(posedge clk_sys);
    rate_drop <= 3'b000;
    rd(`REG_PORT0_TOTAL_DROP_COUNT, 32'h2);
    rd(`REG_PORT1_TOTAL_DROP_COUNT, 32'h3);
    rd(`REG_PORT2_TOTAL_DROP_COUNT, 32'h1);
    rd(`REG_PORT0_RATE_DROP_COUNT, 32'h0);
    rd(`REG_PORT1_RATE_DROP_COUNT, 32'h3);
    rd(`REG_PORT2_RATE_DROP_COUNT, 32'h1);
    @(posedge clk_sys);
    stall <= 1'b1;
    pkt_valid <= 1'b1;
    acc = 0;
    repeat (12) begin
      @(negedge clk_sys);
      if (pkt_valid && pkt_ready) acc++;
    end
    @(posedge clk_sys);
    pkt_valid <= 1'b0;
    chk(acc, 8);
    base = pops;
    stall <= 1'b0;
    slow <= 1'b1;
    repeat (30) @(posedge clk_sys);
    #1 chk({edit_valid, pops - base}, 9'h008);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk({edit_valid, pkt_ready}, 2'b01);
    rd(`REG_PORT1_DEFAULT_VID_PRIO, 32'h0001);
    rd(`REG_EGRESS_PORT_TAG_CONFIG, 32'h0);
    rd(`REG_PORT1_RATE_DROP_COUNT, 32'h0);
    conclude();
  end
endmodule // egress_vlan_tag_editor_test
